// >>> hdl/ncf_channel.sv
/*
 One channel front end: tuned oscillator mixer, start and hop hold-off
 counters, sync pin selection and a decimating filter, with an AHB-Lite
 register slave. Assumes sync pins and samples synchronous to clk.
*/
// Design decisions made here: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`include "ncf_map.svh"
module ncf_channel #(
   parameter logic [2:0] CHANNEL_ID = 3'h0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // Sync pins
   input wire ncf_pkg::ncf_sync_t syncPins,
   // Samples from crossbar
   input wire logic inValid,
   input wire ncf_pkg::ncf_sample_t inData,
   // Samples to later stages
   output logic outValid,
   output ncf_pkg::ncf_out_t outI,
   output ncf_pkg::ncf_out_t outQ
);
   import ncf_pkg::*;

   logic [8:0] ctrl_ff;
   logic [15:0] startHold_ff;
   logic [15:0] hopHold_ff;
   logic [31:0] tuneShadow_ff;
   logic [15:0] phaseOff_ff;
   logic cicByp_ff;
   logic [4:0] cicRate_ff;
   logic [4:0] cicScale_ff;
   logic [5:0] chanSel_ff;
   logic wrPend_ff;
   logic [7:0] wrIdx_ff;
   logic [31:0] rdData_ff;
   logic [31:0] nxt_rdData;
   logic addrTaken;
   logic chanWr;
   logic swStart_ff;
   logic swHop_ff;
   ncf_sync_t syncPrev_ff;
   ncf_sync_t pinEvt;
   logic startEvt;
   logic hopEvt;
   ncf_state_t state_ff;
   logic [15:0] startCnt_ff;
   logic startDone;
   logic hopPend_ff;
   logic [15:0] hopCnt_ff;
   logic hopDone;
   logic [31:0] actTune_ff;
   logic [31:0] acc_ff;
   logic [15:0] lfsr_ff;
   logic [15:0] phSum;
   logic signed [15:0] cosVal;
   logic signed [15:0] sinVal;
   logic signed [31:0] prodI;
   logic signed [31:0] prodQ;
   logic signed [31:0] prodSumI;
   logic signed [31:0] prodSumQ;
   logic [14:0] ampDith;
   logic mixValid_ff;
   ncf_sample_t mixI_ff;
   ncf_sample_t mixQ_ff;
   logic running;
   logic advance;

   // Quarter-wave sine table, sign and mirror from phase
   function automatic logic signed [15:0] ncfSine(input logic [5:0] p);
      logic [3:0] i;
      logic [15:0] m;
      i = p[4] ? ~p[3:0] : p[3:0];
      unique case (i)
         4'h0: m = 16'h0648;
         4'h1: m = 16'h12C8;
         4'h2: m = 16'h1F1A;
         4'h3: m = 16'h2B1F;
         4'h4: m = 16'h36BA;
         4'h5: m = 16'h41CE;
         4'h6: m = 16'h4C3B;
         4'h7: m = 16'h55F6;
         4'h8: m = 16'h5ED7;
         4'h9: m = 16'h66CF;
         4'hA: m = 16'h6DC9;
         4'hB: m = 16'h73B5;
         4'hC: m = 16'h7883;
         4'hD: m = 16'h7C29;
         4'hE: m = 16'h7E9C;
         4'hF: m = 16'h7FD8;
      endcase
      return p[5] ? -$signed(m) : $signed(m);
   endfunction : ncfSine

   // Bus address phase and zero-wait answers
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdData_ff;
   assign addrTaken = hsel && htrans[1] && hready;
   assign chanWr = wrPend_ff && chanSel_ff[CHANNEL_ID];

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wrPend_ff <= 1'b0;
         wrIdx_ff <= 8'h00;
      end else if (hready) begin
         wrPend_ff <= addrTaken && hwrite && (haddr[11:10] == 2'h0);
         wrIdx_ff <= haddr[9:2];
      end
   end

   always_comb begin
      nxt_rdData = 32'h0000_0000;
      if (haddr[11:10] == 2'h0) begin
         unique case (haddr[9:2])
            `NCF_IDX_CHAN_ACCESS: nxt_rdData[5:0] = chanSel_ff;
            `NCF_IDX_CTRL: nxt_rdData[8:0] = ctrl_ff;
            `NCF_IDX_START_HOLD: nxt_rdData[15:0] = startHold_ff;
            `NCF_IDX_HOP_HOLD: nxt_rdData[15:0] = hopHold_ff;
            `NCF_IDX_TUNE: nxt_rdData = tuneShadow_ff;
            `NCF_IDX_PHASE: nxt_rdData[15:0] = phaseOff_ff;
            `NCF_IDX_CIC_BYP: nxt_rdData[0] = cicByp_ff;
            `NCF_IDX_CIC_RATE: nxt_rdData[4:0] = cicRate_ff;
            `NCF_IDX_CIC_SCALE: nxt_rdData[4:0] = cicScale_ff;
            `NCF_IDX_STATUS: nxt_rdData[2:0] =
               {hopPend_ff, state_ff == NCF_START_WAIT, running};
            `NCF_IDX_ACT_TUNE: nxt_rdData = actTune_ff;
            default: nxt_rdData = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdData_ff <= 32'h0000_0000;
      end else if (addrTaken && !hwrite) begin
         rdData_ff <= nxt_rdData;
      end
   end

   // Register writes in the data phase
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         chanSel_ff <= `NCF_CHAN_ACCESS_RST;
         ctrl_ff <= `NCF_CTRL_RST;
         startHold_ff <= `NCF_HOLD_RST;
         hopHold_ff <= `NCF_HOLD_RST;
         tuneShadow_ff <= `NCF_TUNE_RST;
         phaseOff_ff <= `NCF_PHASE_RST;
         cicByp_ff <= `NCF_CIC_BYP_RST;
         cicRate_ff <= `NCF_CIC_RATE_RST;
         cicScale_ff <= `NCF_CIC_SCALE_RST;
      end else begin
         if (wrPend_ff && wrIdx_ff == `NCF_IDX_CHAN_ACCESS) begin
            chanSel_ff <= hwdata[5:0];
         end
         if (chanWr) begin
            unique case (wrIdx_ff)
               `NCF_IDX_CTRL: ctrl_ff <= hwdata[8:0];
               `NCF_IDX_START_HOLD: startHold_ff <= hwdata[15:0];
               `NCF_IDX_HOP_HOLD: hopHold_ff <= hwdata[15:0];
               `NCF_IDX_TUNE: tuneShadow_ff <= hwdata;
               `NCF_IDX_PHASE: phaseOff_ff <= hwdata[15:0];
               `NCF_IDX_CIC_BYP: cicByp_ff <= hwdata[0];
               `NCF_IDX_CIC_RATE: cicRate_ff <= hwdata[4:0];
               `NCF_IDX_CIC_SCALE: cicScale_ff <= hwdata[4:0];
               default: ;
            endcase
         end
      end
   end

   // Software sync strobes
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         swStart_ff <= 1'b0;
         swHop_ff <= 1'b0;
      end else begin
         swStart_ff <= chanWr && wrIdx_ff == `NCF_IDX_COMMAND &&
            hwdata[`NCF_CMD_START_BIT];
         swHop_ff <= chanWr && wrIdx_ff == `NCF_IDX_COMMAND &&
            hwdata[`NCF_CMD_HOP_BIT];
      end
   end

   // Sync pin edges and selection
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         syncPrev_ff <= 4'h0;
      end else begin
         syncPrev_ff <= syncPins;
      end
   end
   assign pinEvt = syncPins & ~syncPrev_ff;
   assign startEvt = swStart_ff ||
      pinEvt[ctrl_ff[`NCF_START_SEL_MSB:`NCF_START_SEL_LSB]];
   assign hopEvt = swHop_ff ||
      pinEvt[ctrl_ff[`NCF_HOP_SEL_MSB:`NCF_HOP_SEL_LSB]];

   // Start hold-off and channel state
   assign startDone = (state_ff == NCF_START_WAIT) && (startCnt_ff == 16'h0);
   assign running = (state_ff == NCF_RUN);
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_ff <= NCF_IDLE;
         startCnt_ff <= 16'h0000;
      end else if (startEvt) begin
         state_ff <= NCF_START_WAIT;
         startCnt_ff <= startHold_ff;
      end else if (startDone) begin
         state_ff <= NCF_RUN;
      end else if (state_ff == NCF_START_WAIT) begin
         startCnt_ff <= startCnt_ff - 16'h0001;
      end
   end

   // Hop hold-off and active tuning word
   assign hopDone = hopPend_ff && (hopCnt_ff == 16'h0);
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         hopPend_ff <= 1'b0;
         hopCnt_ff <= 16'h0000;
      end else if (hopEvt) begin
         hopPend_ff <= 1'b1;
         hopCnt_ff <= hopHold_ff;
      end else if (hopDone) begin
         hopPend_ff <= 1'b0;
      end else if (hopPend_ff) begin
         hopCnt_ff <= hopCnt_ff - 16'h0001;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         actTune_ff <= `NCF_TUNE_RST;
      end else if (hopDone || startDone) begin
         actTune_ff <= tuneShadow_ff;
      end
   end

   // Phase accumulator
   assign advance = running && inValid && !ctrl_ff[`NCF_BYPASS_BIT];
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         acc_ff <= 32'h0000_0000;
      end else if (startEvt) begin
         acc_ff <= {phaseOff_ff, 16'h0000};
      end else if (hopDone && ctrl_ff[`NCF_ACC_CLR_BIT]) begin
         acc_ff <= {phaseOff_ff, 16'h0000};
      end else if (advance) begin
         acc_ff <= acc_ff + actTune_ff;
      end
   end

   // Dither source
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         lfsr_ff <= `NCF_LFSR_SEED;
      end else begin
         lfsr_ff <= {lfsr_ff[14:0],
            lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
      end
   end

   // Phase to amplitude and mixing
   assign phSum = acc_ff[31:16] + (ctrl_ff[`NCF_PH_DITHER_BIT] ?
      {6'h00, lfsr_ff[`NCF_PHASE_DITHER_BITS-1:0]} : 16'h0000);
   assign sinVal = ncfSine(phSum[15:16-`NCF_LUT_BITS]);
   assign cosVal = ncfSine(phSum[15:16-`NCF_LUT_BITS] + 6'h10);
   assign prodI = inData * cosVal;
   assign prodQ = inData * sinVal;
   assign ampDith = ctrl_ff[`NCF_AMP_DITHER_BIT] ?
      lfsr_ff[15:1] : 15'h0000;
   assign prodSumI = prodI + $signed({17'h00000, ampDith});
   assign prodSumQ = prodQ + $signed({17'h00000, ampDith});

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mixValid_ff <= 1'b0;
         mixI_ff <= '0;
         mixQ_ff <= '0;
      end else begin
         mixValid_ff <= running && inValid;
         if (running && inValid) begin
            if (ctrl_ff[`NCF_BYPASS_BIT]) begin
               mixI_ff <= inData;
               mixQ_ff <= '0;
            end else begin
               mixI_ff <= prodSumI[30:15];
               mixQ_ff <= prodSumQ[30:15];
            end
         end
      end
   end

   // Decimators for both lanes
   ncf_cic uCicI (
      .clk(clk),
      .nrst(nrst),
      .bypass(cicByp_ff),
      .rateM1(cicRate_ff),
      .scale(cicScale_ff),
      .inValid(mixValid_ff),
      .inData(mixI_ff),
      .outValid(outValid),
      .outData(outI)
   );
   ncf_cic uCicQ (
      .clk(clk),
      .nrst(nrst),
      .bypass(cicByp_ff),
      .rateM1(cicRate_ff),
      .scale(cicScale_ff),
      .inValid(mixValid_ff),
      .inData(mixQ_ff),
      .outValid(),
      .outData(outQ)
   );

   // Checks
   property p_startSel;
      @(posedge clk) disable iff (!nrst)
      (pinEvt[ctrl_ff[8:7]] && !swStart_ff) |=>
         (state_ff == NCF_START_WAIT) && (startCnt_ff == $past(startHold_ff));
   endproperty
   a_startSel: assert property (p_startSel)
      else $error("selected start pin did not start hold-off");

   property p_hopSel;
      @(posedge clk) disable iff (!nrst)
      pinEvt[ctrl_ff[6:5]] |=> hopPend_ff && hopCnt_ff == $past(hopHold_ff);
   endproperty
   a_hopSel: assert property (p_hopSel)
      else $error("selected hop pin did not load hop counter");

   property p_bypass;
      @(posedge clk) disable iff (!nrst)
      (running && inValid && ctrl_ff[3]) |=>
         mixValid_ff && mixI_ff == $past(inData) && mixQ_ff == 16'h0000;
   endproperty
   a_bypass: assert property (p_bypass)
      else $error("bypassed oscillator altered the sample");

   property p_hopClear;
      @(posedge clk) disable iff (!nrst)
      (hopDone && ctrl_ff[2] && !startEvt) |=>
         acc_ff == {$past(phaseOff_ff), 16'h0000};
   endproperty
   a_hopClear: assert property (p_hopClear)
      else $error("hop did not reload accumulator");

   property p_hopKeep;
      @(posedge clk) disable iff (!nrst)
      (hopDone && !ctrl_ff[2] && !startEvt && !advance) |=> $stable(acc_ff);
   endproperty
   a_hopKeep: assert property (p_hopKeep)
      else $error("phase continuous hop disturbed accumulator");

   property p_noDither;
      @(posedge clk) disable iff (!nrst)
      (!ctrl_ff[1] |-> phSum == acc_ff[31:16]) and
      (!ctrl_ff[0] |-> prodSumI == prodI);
   endproperty
   a_noDither: assert property (p_noDither)
      else $error("dither applied while disabled");

   property p_dither;
      @(posedge clk) disable iff (!nrst)
      (ctrl_ff[1] && lfsr_ff[9:0] != 10'h000 |-> phSum != acc_ff[31:16]) and
      (ctrl_ff[0] && lfsr_ff[15:1] != 15'h0000 |-> prodSumI != prodI);
   endproperty
   a_dither: assert property (p_dither)
      else $error("dither missing while enabled");

   property p_startRun;
      @(posedge clk) disable iff (!nrst)
      (startDone && !startEvt) |=> running && actTune_ff == $past(tuneShadow_ff);
   endproperty
   a_startRun: assert property (p_startRun)
      else $error("channel did not run at hold-off zero");

   property p_hopExpire;
      @(posedge clk) disable iff (!nrst)
      (hopDone && !hopEvt) |=>
         !hopPend_ff && actTune_ff == $past(tuneShadow_ff);
   endproperty
   a_hopExpire: assert property (p_hopExpire)
      else $error("hop expiry did not load tuning word");

   property p_shadowHold;
      @(posedge clk) disable iff (!nrst)
      (!hopDone && !startDone) |=> $stable(actTune_ff);
   endproperty
   a_shadowHold: assert property (p_shadowHold)
      else $error("active tuning word changed without expiry");

   property p_chanGate;
      @(posedge clk) disable iff (!nrst)
      (wrPend_ff && !chanSel_ff[CHANNEL_ID] && wrIdx_ff == 8'h10) |=>
         $stable(ctrl_ff);
   endproperty
   a_chanGate: assert property (p_chanGate)
      else $error("unselected channel accepted a write");
endmodule : ncf_channel

// >>> hdl/ncf_map.svh
/*
 Register indices, field positions, reset values and widths of the channel
 oscillator and decimator front end. Assumes inclusion by bare name.
*/
`ifndef NCF_MAP_SVH
`define NCF_MAP_SVH

// Register indices; byte address is four times the index
`define NCF_IDX_CHAN_ACCESS 8'h02
`define NCF_IDX_CTRL 8'h10
`define NCF_IDX_START_HOLD 8'h11
`define NCF_IDX_HOP_HOLD 8'h12
`define NCF_IDX_TUNE 8'h13
`define NCF_IDX_PHASE 8'h14
`define NCF_IDX_CIC_BYP 8'h15
`define NCF_IDX_CIC_RATE 8'h16
`define NCF_IDX_CIC_SCALE 8'h17
`define NCF_IDX_COMMAND 8'h18
`define NCF_IDX_STATUS 8'h19
`define NCF_IDX_ACT_TUNE 8'h1A

// Oscillator control fields
`define NCF_START_SEL_MSB 8
`define NCF_START_SEL_LSB 7
`define NCF_HOP_SEL_MSB 6
`define NCF_HOP_SEL_LSB 5
`define NCF_BYPASS_BIT 3
`define NCF_ACC_CLR_BIT 2
`define NCF_PH_DITHER_BIT 1
`define NCF_AMP_DITHER_BIT 0

// Command fields
`define NCF_CMD_START_BIT 0
`define NCF_CMD_HOP_BIT 1

// Reset values
`define NCF_CTRL_RST 9'h000
`define NCF_HOLD_RST 16'h0000
`define NCF_TUNE_RST 32'h0000_0000
`define NCF_PHASE_RST 16'h0000
`define NCF_CIC_BYP_RST 1'h1
`define NCF_CIC_RATE_RST 5'h00
`define NCF_CIC_SCALE_RST 5'h00
`define NCF_CHAN_ACCESS_RST 6'h3F
`define NCF_LFSR_SEED 16'hACE1

// Oscillator geometry
`define NCF_PHASE_DITHER_BITS 10
`define NCF_LUT_BITS 6

`endif

// >>> hdl/ncf_pkg.sv
/*
 Types shared by the channel front end. Assumes nothing of its surroundings.
*/
package ncf_pkg;
   typedef enum logic [1:0] {
      NCF_IDLE,
      NCF_START_WAIT,
      NCF_RUN
   } ncf_state_t;
   typedef logic signed [15:0] ncf_sample_t;
   typedef logic signed [20:0] ncf_out_t;
   typedef logic [3:0] ncf_sync_t;
endpackage : ncf_pkg

// >>> hdl/ncf_cic.sv
/*
 Five-stage decimating comb-integrator filter with rate, scale and bypass.
 Assumes input samples arrive as one-cycle valid strobes.
*/
`timescale 1ns/1ps
module ncf_cic #(
   parameter int IW = 16,
   parameter int OW = 21,
   parameter int STAGES = 5,
   parameter int AW = 41
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Settings
   input wire logic bypass,
   input wire logic [4:0] rateM1,
   input wire logic [4:0] scale,
   // Sample in
   input wire logic inValid,
   input wire logic signed [IW-1:0] inData,
   // Sample out
   output logic outValid,
   output logic signed [OW-1:0] outData
);
   logic signed [AW-1:0] ext;
   logic signed [AW-1:0] integ_ff [STAGES];
   logic signed [AW-1:0] combDly_ff [STAGES];
   logic signed [AW-1:0] diff [STAGES+1];
   logic signed [AW-1:0] scaled;
   logic signed [AW-1:0] direct;
   logic [4:0] phase_ff;
   logic dump;

   assign ext = {{(AW-IW){inData[IW-1]}}, inData};
   assign dump = (phase_ff == rateM1);
   assign diff[0] = integ_ff[STAGES-1];
   assign scaled = diff[STAGES] >>> scale;
   assign direct = ext >>> scale;

   // Integrator and comb chains
   for (genvar g = 0; g < STAGES; g++) begin : gStage
      always_ff @(posedge clk or negedge nrst) begin
         if (!nrst) begin
            integ_ff[g] <= '0;
         end else if (inValid) begin
            if (g == 0) begin
               integ_ff[g] <= integ_ff[g] + ext;
            end else begin
               integ_ff[g] <= integ_ff[g] + integ_ff[(g > 0) ? g-1 : 0];
            end
         end
      end
      assign diff[g+1] = diff[g] - combDly_ff[g];
      always_ff @(posedge clk or negedge nrst) begin
         if (!nrst) begin
            combDly_ff[g] <= '0;
         end else if (inValid && dump) begin
            combDly_ff[g] <= diff[g];
         end
      end
   end

   // Decimation phase
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         phase_ff <= 5'h00;
      end else if (inValid) begin
         phase_ff <= dump ? 5'h00 : phase_ff + 5'h01;
      end
   end

   // Output select
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         outValid <= 1'b0;
         outData <= '0;
      end else begin
         outValid <= 1'b0;
         if (inValid) begin
            if (bypass) begin
               outValid <= 1'b1;
               outData <= ext[OW-1:0];
            end else if (rateM1 == 5'h00) begin
               outValid <= 1'b1;
               outData <= direct[OW-1:0];
            end else if (dump) begin
               outValid <= 1'b1;
               outData <= scaled[OW-1:0];
            end
         end
      end
   end
endmodule : ncf_cic

// >>> verification/ncf_source.sv
/*
 Input crossbar and sync pin source model for one channel.
 Assumes bench requests change just after rising clock edges.
*/
`timescale 1ns/1ps
module ncf_source (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Bench requests
   input wire logic [3:0] pinReq,
   input wire logic smpReq,
   input wire logic [15:0] smpVal,
   // Toward the channel
   output ncf_pkg::ncf_sync_t syncPins,
   output logic inValid,
   output ncf_pkg::ncf_sample_t inData
);
   import ncf_pkg::*;
   ncf_sync_t pins_ff;
   logic valid_ff;
   ncf_sample_t data_ff;
   assign syncPins = pins_ff;
   assign inValid = valid_ff;
   assign inData = data_ff;
   // One-cycle pin pulse per request, idle low
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pins_ff <= 4'h0;
      end else begin
         pins_ff <= pinReq;
      end
   end
   // Sample strobe; data toggles when no sample stands
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         valid_ff <= 1'b0;
         data_ff <= 16'h0000;
      end else begin
         valid_ff <= smpReq;
         data_ff <= smpReq ? smpVal : ~data_ff;
      end
   end
endmodule : ncf_source

// >>> verification/tb.sv
/*
 Self-checking bench: register bus, sync pins and sample path of one
 channel. Assumes the source model and the channel compile first.
*/
`timescale 1ns/1ps
`include "ncf_map.svh"
module tb;
   import ncf_pkg::*;
   logic clk, nrst, hsel, hwrite, hreadyout, hresp, smpReq, outValid;
   logic [11:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, rd, capI, capQ;
   logic [3:0] pinReq;
   logic [15:0] smpVal;
   ncf_sync_t syncPins;
   logic inValid;
   ncf_sample_t inData;
   ncf_out_t outI, outQ;
   int failures = 0;
   int compares = 0;
   int cycles = 0;
   int outCount = 0;
   int rates[3] = '{0, 1, 31};

   ncf_source src_u (.clk(clk), .nrst(nrst), .pinReq(pinReq),
      .smpReq(smpReq), .smpVal(smpVal), .syncPins(syncPins),
      .inValid(inValid), .inData(inData));
   ncf_channel #(.CHANNEL_ID(3'h2)) dut_u (.clk(clk), .nrst(nrst),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .syncPins(syncPins), .inValid(inValid), .inData(inData),
      .outValid(outValid), .outI(outI), .outQ(outQ));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (outValid === 1'b1) outCount++;
      if (cycles == 5000) begin
         failures++;
         test_done();
      end
   end

   task automatic test_done();
      $display("Compares %0d, failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : test_done

   task automatic check(input string what, input logic [31:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // 64-entry wave table: products land within 64 of the ideal
   function automatic logic [31:0] near(input logic [31:0] v, input int e);
      return 32'($signed(v) - e > -64 && $signed(v) - e < 64);
   endfunction : near

   // Single AHB-Lite transfer; read data taken at data-phase edge
   task automatic busOp(input logic wr, input logic [7:0] idx,
         input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {2'b00, idx, 2'b00};
      htrans <= 2'b10;
      hwrite <= wr;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
      check("hresp", {31'h0, hresp}, 32'h0);
   endtask : busOp

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      busOp(1'b1, idx, d);
   endtask : wr

   task automatic rdChk(input string what, input logic [7:0] idx,
         input logic [31:0] exp);
      busOp(1'b0, idx, 32'h0);
      check(what, rd, exp);
   endtask : rdChk

   task automatic pulse(input int k);
      @(posedge clk);
      pinReq <= 4'(1 << k);
      @(posedge clk);
      pinReq <= 4'h0;
      repeat (3) @(posedge clk);
   endtask : pulse

   // One sample in, wait bounded for its output
   task automatic sendOne(input int x);
      int n;
      @(posedge clk);
      smpReq <= 1'b1;
      smpVal <= 16'(x);
      @(posedge clk);
      smpReq <= 1'b0;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (outValid !== 1'b1 && n < 8);
      capI = 32'(outI);
      capQ = 32'(outQ);
   endtask : sendOne

   initial begin
      hsel = 1'b0;
      haddr = 12'h000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      pinReq = 4'h0;
      smpReq = 1'b0;
      smpVal = 16'h0000;
      nrst = 1'b0;
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      rdChk("access", `NCF_IDX_CHAN_ACCESS, 32'h3F);
      rdChk("ctrl", `NCF_IDX_CTRL, 32'h0);
      rdChk("decByp", `NCF_IDX_CIC_BYP, 32'h1);
      rdChk("decRate", `NCF_IDX_CIC_RATE, 32'h0);
      wr(8'h30, 32'hFFFF_FFFF);
      rdChk("unmapped", 8'h30, 32'h0);
      wr(`NCF_IDX_CHAN_ACCESS, 32'h3B);
      wr(`NCF_IDX_CTRL, 32'h1FF);
      rdChk("ctrlBlocked", `NCF_IDX_CTRL, 32'h0);
      wr(`NCF_IDX_CHAN_ACCESS, 32'h04);
      // Start on pin 2, hop on pin 1, oscillator bypassed
      wr(`NCF_IDX_TUNE, 32'h1234_5678);
      wr(`NCF_IDX_START_HOLD, 32'd40);
      wr(`NCF_IDX_HOP_HOLD, 32'd40);
      wr(`NCF_IDX_CTRL, 32'h128);
      pulse(3);
      rdChk("statIdle", `NCF_IDX_STATUS, 32'h0);
      pulse(2);
      rdChk("statPend", `NCF_IDX_STATUS, 32'h2);
      repeat (60) @(posedge clk);
      rdChk("statRun", `NCF_IDX_STATUS, 32'h1);
      rdChk("actTune", `NCF_IDX_ACT_TUNE, 32'h1234_5678);
      // Hop with shadowed tuning
      wr(`NCF_IDX_TUNE, 32'h0ABC_0000);
      pulse(0);
      rdChk("hopIdle", `NCF_IDX_STATUS, 32'h1);
      pulse(1);
      rdChk("hopPend", `NCF_IDX_STATUS, 32'h5);
      wr(`NCF_IDX_TUNE, 32'h0ABC_0001);
      rdChk("tuneHeld", `NCF_IDX_ACT_TUNE, 32'h1234_5678);
      repeat (60) @(posedge clk);
      rdChk("tuneHop", `NCF_IDX_ACT_TUNE, 32'h0ABC_0001);
      sendOne(-300);
      check("bypI", capI, 32'(-300));
      check("bypQ", capQ, 32'h0);
      wr(`NCF_IDX_CIC_BYP, 32'h0);
      wr(`NCF_IDX_CIC_SCALE, 32'd2);
      sendOne(-300);
      check("rate1I", capI, 32'(-300 >>> 2));
      wr(`NCF_IDX_CIC_SCALE, 32'd0);
      foreach (rates[i]) begin
         wr(`NCF_IDX_CIC_RATE, 32'(rates[i]));
         outCount = 0;
         @(posedge clk);
         smpReq <= 1'b1;
         smpVal <= 16'h0064;
         repeat (3 * (rates[i] + 1)) @(posedge clk);
         smpReq <= 1'b0;
         repeat (20) @(posedge clk);
         check("outCount", 32'(outCount), 32'd3);
      end
      // Oscillator on: quarter-turn start phase, then hop clearing
      wr(`NCF_IDX_CIC_BYP, 32'h1);
      wr(`NCF_IDX_TUNE, 32'h0);
      wr(`NCF_IDX_PHASE, 32'h4000);
      wr(`NCF_IDX_START_HOLD, 32'd0);
      wr(`NCF_IDX_CTRL, 32'h100);
      pulse(2);
      sendOne(1000);
      check("quarterI", near(capI, 0), 32'h1);
      check("quarterQ", near(capQ, 1000), 32'h1);
      wr(`NCF_IDX_PHASE, 32'h0);
      wr(`NCF_IDX_CTRL, 32'h104);
      pulse(0);
      repeat (60) @(posedge clk);
      sendOne(1000);
      check("hopClrQ", near(capQ, 0), 32'h1);
      check("hopClrI", near(capI, 1000), 32'h1);
      // Software start and hop commands, dither on
      wr(`NCF_IDX_START_HOLD, 32'd40);
      wr(`NCF_IDX_CTRL, 32'h107);
      wr(`NCF_IDX_COMMAND, 32'h1);
      rdChk("swStart", `NCF_IDX_STATUS, 32'h2);
      wr(`NCF_IDX_COMMAND, 32'h2);
      rdChk("swHop", `NCF_IDX_STATUS, 32'h6);
      test_done();
   end
endmodule : tb
